//--- src/bank_map.vh
// register offsets, field positions, reset values and timing for the memory map
`ifndef BANK_MAP_VH
`define BANK_MAP_VH
`define PC_WIDTH        13
`define CODE_ADDR_MASK  13'h0FFF
`define RESET_VECTOR    13'h0000
`define INTR_VECTOR     13'h0004
`define OFS_INDIRECT    7'h00
`define OFS_STATE       7'h03
`define OFS_POINTER     7'h04
`define BANK_HI_BIT     6
`define BANK_LO_BIT     5
`define STATE_RESET     8'h18
`define POINTER_RESET   8'h00
`define SFR_TOP         7'h1F
`define GPR_B0_LOW      7'h20
`define GPR_B1_LOW      7'h20
`define GPR_B2_LOW      7'h20
`define GPR_B3_LOW      7'h20
`define GPR_B3_HIGH     7'h6F
`define COMMON_LOW      7'h70
`define PHASE_READ      2'h1
`define PHASE_WRITE     2'h3
`endif

//--- src/file_ram.v
// general purpose register storage with registered read data
`timescale 1ns/1ps
module file_ram
(
  input  wire       clk,
  input  wire       write_enable,
  input  wire [8:0] write_addr,
  input  wire [7:0] write_data,
  input  wire       read_enable,
  input  wire [8:0] read_addr,
  output reg  [7:0] read_data
);
  reg [7:0] cells [0:511];

  // read is registered; contents are not cleared by reset, like real sram
  always @(posedge clk)
  begin
    if (write_enable)
      cells[write_addr] <= write_data;
    if (read_enable)
      read_data <= cells[read_addr];
  end
endmodule

//--- src/banked_memory_address_map.v
// program counter and banked data memory decode with file registers
// What this block does
// - the program counter is 13 bits wide, spanning 8K words of code.
// - the smaller variant implements only code words 0000h to 0FFFh.
// - code addresses above the implemented space wrap back into it.
// - fetch starts at 0000h after reset and jumps to 0004h on interrupt.
// - data memory is four banks of 128 locations each.
// - state bits 6:5 choose the bank, 11 to 00 giving banks 3 to 0.
// - each bank holds special registers low and general sram above.
// - common special registers are mirrored so all banks reach one copy.
// - every location is reachable directly or through the file pointer.
// - F0h-FFh, 170h-17Fh and 1F0h-1FFh all reach 70h-7Fh of bank 0.
// - the operand is read in phase two and written back in phase four.
`timescale 1ns/1ps
`include "bank_map.vh"
module banked_memory_address_map
(
  input  wire        clk,
  input  wire        reset,
  input  wire        small_variant,
  input  wire        pc_load,
  input  wire [12:0] pc_load_value,
  input  wire        interrupt_take,
  input  wire        data_access,
  input  wire [6:0]  direct_addr,
  input  wire        data_write,
  input  wire [7:0]  write_value,
  output reg  [12:0] program_counter,
  output wire [12:0] code_addr,
  output reg  [1:0]  phase,
  output reg  [7:0]  operand,
  output reg         operand_valid,
  output reg  [7:0]  processor_state,
  output reg  [7:0]  file_pointer,
  output reg  [8:0]  data_addr,
  output wire        bank_select_high,
  output wire        bank_select_low,
  output wire        operand_read_phase,
  output wire        destination_write_phase
);
  reg  [12:0] next_pc;
  reg  [8:0]  next_addr;
  reg  [8:0]  phys_addr;
  reg         phys_ram;
  reg  [1:0]  phys_reg;
  reg         mapped;
  reg  [8:0]  latched_addr;
  reg  [1:0]  latched_reg;
  reg         latched_ram;
  reg         latched_ok;
  reg         pending;
  reg         ram_pending;
  reg  [7:0]  reg_value;
  wire [7:0]  ram_data;
  wire [6:0]  low;
  wire [1:0]  bank;
  wire        indirect_slot;
  wire [6:0]  slot;
  wire        slot_state;
  wire        slot_pointer;
  wire        slot_common;
  reg         bank_ram;
  reg         access_live;
  wire        reg_write;
  wire        ram_write;

  localparam REG_NONE    = 2'h0;
  localparam REG_STATE   = 2'h1;
  localparam REG_POINTER = 2'h2;

  assign bank_select_high = processor_state[`BANK_HI_BIT];
  assign bank_select_low  = processor_state[`BANK_LO_BIT];
  assign operand_read_phase      = (phase == `PHASE_READ);
  assign destination_write_phase = (phase == `PHASE_WRITE);

  // fold the 13-bit counter onto the 4K array on the small part
  // the fetch address is combinational so it follows the counter at once
  assign code_addr = small_variant ?
                     (program_counter & `CODE_ADDR_MASK) :
                     program_counter;

  // four-phase instruction cycle, one phase per clock
  // phase codes 0 to 3 stand for the four quarter clocks of the cycle
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end

  // program counter steps once per cycle in phase one
  always @*
  begin
    next_pc = program_counter;
    if (phase == 2'h0)
    begin
      if (interrupt_take)
        next_pc = `INTR_VECTOR;
      else if (pc_load)
        next_pc = pc_load_value;
      else
        next_pc = program_counter + 13'h0001; // wraps at 8K
    end
  end

  // counter register; reset puts the first fetch on the reset vector
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      program_counter <= `RESET_VECTOR;
    else
      program_counter <= next_pc;
  end

  // the indirect slot swaps in the pointer, bank 9th bit from state bit 7;
  // a pointer that names the slot again lands on a hole and reads zero
  assign low           = direct_addr;
  assign bank          = {bank_select_high, bank_select_low};
  assign indirect_slot = (low == `OFS_INDIRECT);

  // logical nine-bit address of this access
  always @*
  begin
    if (indirect_slot)
      next_addr = {processor_state[7], file_pointer};
    else
      next_addr = {bank, low};
  end

  // offset kinds inside the addressed bank; the two core registers answer
  // in every bank, so one flop serves all four mirrored slots
  assign slot         = next_addr[6:0];
  assign slot_state   = (slot == `OFS_STATE);
  assign slot_pointer = (slot == `OFS_POINTER);
  assign slot_common  = (slot >= `COMMON_LOW);

  // sram span of each bank below the shared window; the special function
  // slots under it stay out so they can never alias storage
  always @*
  begin
    case (next_addr[8:7])
      2'h0: bank_ram = (slot >= `GPR_B0_LOW);
      2'h1: bank_ram = (slot >= `GPR_B1_LOW);
      2'h2: bank_ram = (slot >= `GPR_B2_LOW);
      2'h3: bank_ram = (slot >= `GPR_B3_LOW) &&
                       (slot <= `GPR_B3_HIGH);
      default: bank_ram = 1'b0;
    endcase
  end

  // physical decode: mirrors, common window, sram, holes; a hole keeps
  // mapped low, which both zeroes the read and blocks the write
  always @*
  begin
    phys_addr = next_addr;
    phys_ram  = 1'b0;
    phys_reg  = REG_NONE;
    mapped    = 1'b0;
    // the core registers come first so their slots never fall into sram
    if (slot_state)
    begin
      phys_reg = REG_STATE; // mirrored in all banks
      mapped   = 1'b1;
    end
    else if (slot_pointer)
    begin
      phys_reg = REG_POINTER; // mirrored in all banks
      mapped   = 1'b1;
    end
    else if (slot_common)
    begin
      phys_addr = {2'h0, slot}; // shared window
      phys_ram  = 1'b1;
      mapped    = 1'b1;
    end
    else
    begin
      phys_ram = bank_ram;
      mapped   = bank_ram; // other special slots are holes
    end
  end

  // capture the address in phase two; register read data lands for phase four
  // the write in phase four reuses this capture, so it needs no address
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      latched_addr <= 9'h000;
      latched_reg  <= REG_NONE;
      latched_ram  <= 1'b0;
      latched_ok   <= 1'b0;
      pending      <= 1'b0;
      ram_pending  <= 1'b0;
      data_addr    <= 9'h000;
    end
    else
    begin
      pending     <= 1'b0;
      ram_pending <= 1'b0;
      if (operand_read_phase && data_access)
      begin
        latched_addr <= phys_addr;
        latched_reg  <= phys_reg;
        latched_ram  <= phys_ram;
        latched_ok   <= mapped;
        data_addr    <= next_addr;
        pending      <= 1'b1;
        ram_pending  <= phys_ram;
      end
    end
  end

  // a write strobe only counts in the cycle of its own operand fetch, so a
  // stray strobe cannot replay the previous access into stale storage
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      access_live <= 1'b0;
    else if (operand_read_phase)
      access_live <= data_access;
  end

  // write strobes for the two kinds of storage; holes take neither, and
  // a mapped slot takes only the one that matches its kind
  assign reg_write = destination_write_phase & data_write & access_live &
                     latched_ok & ~latched_ram;
  assign ram_write = destination_write_phase & data_write & access_live &
                     latched_ok & latched_ram;

  // register value selected for the operand; unused codes give zero
  // rather than a stale value
  always @*
  begin
    case (latched_reg)
      REG_STATE:   reg_value = processor_state;
      REG_POINTER: reg_value = file_pointer;
      default:     reg_value = 8'h00;
    endcase
  end

  // valid pulse one clock after the capture, which puts it in phase four
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      operand_valid <= 1'b0;
    else
      operand_valid <= pending;
  end

  // operand register; holes give zero, sram data follows one clock later
  // because the storage read is registered
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      operand <= 8'h00;
    else
    begin
      if (pending)
      begin
        if (!latched_ok)
          operand <= 8'h00;
        else if (latched_ram)
          operand <= 8'h00;
        else
          operand <= reg_value;
      end
      else if (operand_valid && latched_ram)
        operand <= ram_data;
    end
  end

  // state register; only mapped, fetched accesses may write it
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      processor_state <= `STATE_RESET;
    else if (reg_write && latched_reg == REG_STATE)
      processor_state <= write_value;
  end

  // pointer register, same write timing as the state register
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      file_pointer <= `POINTER_RESET;
    else if (reg_write && latched_reg == REG_POINTER)
      file_pointer <= write_value;
  end

  // sram: read with phase two address, written in phase four
  // the read runs one clock after capture, so sram operands arrive last
  file_ram ram
  (
    .clk          (clk),
    .write_enable (ram_write),
    .write_addr   (latched_addr),
    .write_data   (write_value),
    .read_enable  (ram_pending),
    .read_addr    (latched_addr),
    .read_data    (ram_data)
  );
endmodule

//--- test/map_monitor.sv
// port assertions for the banked memory map
`timescale 1ns/1ps
module map_monitor
(
  input wire        clk,
  input wire        reset,
  input wire        small_variant,
  input wire        interrupt_take,
  input wire        data_access,
  input wire        pc_load,
  input wire [6:0]  direct_addr,
  input wire [7:0]  file_pointer,
  input wire [8:0]  data_addr,
  input wire        operand_read_phase,
  input wire        destination_write_phase,
  input wire [12:0] program_counter,
  input wire [12:0] code_addr,
  input wire [1:0]  phase,
  input wire        operand_valid,
  input wire [7:0]  processor_state,
  input wire        bank_select_high,
  input wire        bank_select_low
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_code_wrap: assert property (small_variant |->
    code_addr == {1'h0, program_counter[11:0]}) else $error("wrap");
  a_code_full: assert property (!small_variant |->
    code_addr == program_counter) else $error("code");
  a_intr_vector: assert property (phase == 2'h0 && interrupt_take
    |=> program_counter == 13'h0004) else $error("vector");
  a_bank_bits: assert property (processor_state[6:5] ==
    {bank_select_high, bank_select_low}) else $error("bank");
  a_phase_step: assert property (1'h1 |=>
    phase == $past(phase) + 2'h1) else $error("phase");
  a_operand_due: assert property (phase == 2'h1 && data_access
    |-> ##2 operand_valid) else $error("late");
  a_valid_phase: assert property (operand_valid |->
    phase == 2'h3) else $error("valid");
  a_valid_gap: assert property (operand_valid |=>
    !operand_valid [*3]) else $error("gap");
  a_read_strobe: assert property (operand_read_phase ==
    (phase == 2'h1)) else $error("read strobe");
  a_write_strobe: assert property (destination_write_phase ==
    (phase == 2'h3)) else $error("write strobe");
  a_pc_step: assert property (phase == 2'h0 && !interrupt_take &&
    !pc_load |=> program_counter == $past(program_counter) + 13'h0001)
    else $error("step");
  a_pc_hold: assert property (phase != 2'h0 |=>
    $stable(program_counter)) else $error("hold");
  a_direct_addr: assert property (phase == 2'h1 && data_access &&
    direct_addr != 7'h00 |=> data_addr == {$past(processor_state[6:5]),
    $past(direct_addr)}) else $error("direct");
  a_indirect_addr: assert property (phase == 2'h1 && data_access &&
    direct_addr == 7'h00 |=> data_addr == {$past(processor_state[7]),
    $past(file_pointer)}) else $error("indirect");
  c_vector: cover property (phase == 2'h0 && interrupt_take);
  c_bank3: cover property (operand_valid && processor_state[6:5] == 2'h3);
  c_small: cover property (small_variant && program_counter[12]);
  c_indirect: cover property (phase == 2'h1 && data_access &&
    direct_addr == 7'h00);
endmodule
bind banked_memory_address_map map_monitor u_mon (.clk, .reset,
  .small_variant, .interrupt_take, .data_access, .pc_load, .direct_addr,
  .file_pointer, .data_addr, .operand_read_phase, .destination_write_phase,
  .program_counter, .code_addr, .phase, .operand_valid, .processor_state,
  .bank_select_high, .bank_select_low);

//--- test/cpu_core_model.sv
// core side model raising one operand access per instruction cycle
`timescale 1ns/1ps
module cpu_core_model
(
  input  wire       clk,
  input  wire [1:0] phase,
  input  wire [7:0] operand,
  output reg        data_access = 1'h0,
  output reg  [6:0] direct_addr = 7'h00,
  output reg        data_write = 1'h0,
  output reg  [7:0] write_value = 8'h00
);
  // phase waits that run out are counted here and added by the bench
  integer misses = 0;
  // request shows in phase two; released lines carry the inverse value
  task xfer(input [6:0] a, input w, input [7:0] v, output [7:0] rd);
    begin
      repeat (4) if (phase !== 2'h1) @(posedge clk) #1;
      if (phase !== 2'h1) misses = misses + 1;
      {data_access, direct_addr} = {1'h1, a};
      @(posedge clk) #1;
      {data_access, direct_addr} = {1'h0, ~a};
      {data_write, write_value} = {w, v};
      repeat (2) @(posedge clk) #1;
      {data_write, write_value} = {1'h0, ~v};
      rd = operand;
    end
  endtask
endmodule

//--- test/tb_top.sv
// random traffic bench for the banked memory map
`timescale 1ns/1ps
module tb_top;
  reg         clk, reset, small_variant, pc_load, interrupt_take;
  reg  [12:0] pc_load_value;
  wire        data_access, data_write;
  wire [6:0]  direct_addr;
  wire [7:0]  write_value, operand, processor_state, file_pointer;
  wire [12:0] program_counter, code_addr;
  wire [1:0]  phase;
  integer     error_cnt = 0, checked = 0, i, k, e, seed, a, b, rd, m [0:511];
  banked_memory_address_map u_dut (.clk, .reset, .small_variant, .pc_load,
    .pc_load_value, .interrupt_take, .data_access, .direct_addr, .data_write,
    .write_value, .program_counter, .code_addr, .phase, .operand,
    .operand_valid(), .processor_state, .file_pointer, .data_addr(),
    .bank_select_high(), .bank_select_low(), .operand_read_phase(),
    .destination_write_phase());
  cpu_core_model u_cpu (.clk, .phase, .operand, .data_access, .direct_addr,
    .data_write, .write_value);
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  function integer xs(input integer s);
    begin
      xs = s ^ (s << 13);
      xs = xs ^ (xs >>> 17 & 32'h00007FFF);
      xs = xs ^ (xs << 5);
    end
  endfunction
  // storage slot of a logical address, -1 where nothing is kept
  function integer loc(input [8:0] x);
    if (x[6:0] >= 7'h70) loc = x[6:0];
    else if (x[6:0] >= 7'h20) loc = x;
    else loc = -1;
  endfunction
  task chk(input [31:0] g, input [31:0] x);
    begin
      checked = checked + 1;
      error_cnt = error_cnt + (g !== x);
      if (g !== x) $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask
  task stop_test;
    begin
      error_cnt = error_cnt + u_cpu.misses;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // direct write under the bank bits, read back through the pointer
  initial
  begin
    {reset, small_variant, pc_load, interrupt_take, pc_load_value} = 17'h10000;
    seed = 58;
    for (i = 0; i < 512; i = i + 1) m[i] = -1;
    repeat (2) @(posedge clk) #1;
    reset = 1'h0;
    chk({program_counter, processor_state, file_pointer}, 29'h1800);
    for (i = 0; i < 60; i = i + 1)
    begin
      seed = xs(seed);
      a = {seed[8:7], 7'h05 + seed[6:0] % 7'h7B};
      b = {seed[10:9], a[6:0]};
      k = loc(a[8:0]);
      if (k >= 0) m[k] = seed[23:16];
      u_cpu.xfer(7'h03, 1'h1, {1'h0, seed[8:7], 5'h18}, rd);
      u_cpu.xfer(a[6:0], 1'h1, seed[23:16], rd);
      u_cpu.xfer(7'h03, 1'h1, {seed[10], 7'h18}, rd);
      u_cpu.xfer(7'h04, 1'h1, b[7:0], rd);
      u_cpu.xfer(7'h00, 1'h0, 8'h00, rd);
      k = loc(b[8:0]);
      if (k < 0 || m[k] >= 0) chk(rd, k < 0 ? 0 : m[k]);
      repeat (4) if (phase !== 2'h0) @(posedge clk) #1;
      chk(phase, 2'h0);
      {pc_load, interrupt_take, small_variant, pc_load_value} =
        {1'h1, seed[30:16]};
      @(posedge clk) #1;
      {pc_load, interrupt_take} = 2'h0;
      e = seed[30] ? 13'h0004 : seed[28:16];
      chk(program_counter, e);
      chk(code_addr, seed[29] ? e & 13'h0FFF : e);
    end
    stop_test;
  end
endmodule
